// file: sca_defs.svh
`ifndef SCA_DEFS_SVH
`define SCA_DEFS_SVH

// Command codes
`define SCA_CMD_WR_CHAL     8'h0c
`define SCA_CMD_MAC_ANON    8'h36
`define SCA_CMD_MAC_ID      8'h35
`define SCA_CMD_FETCH_ID    8'h39
`define SCA_CMD_FETCH_MAC   8'h3a
`define SCA_CMD_CLR_SECRET  8'h5a
`define SCA_CMD_NEXT_ANON   8'h30
`define SCA_CMD_NEXT_ID     8'h33
`define SCA_CMD_LOCK        8'h60

// Field sizes
`define SCA_CHAL_BYTES      4'h8
`define SCA_ID_LEN          8'h40
`define SCA_DIGEST_LEN      8'ha0
`define SCA_SHA_LAST_ROUND  7'h4f

// Reset values of the nonvolatile copies
`define SCA_SECRET_RST      64'h0000_0000_0000_0000
`define SCA_LOCK_RST        1'b0

// EEPROM write time and its cycle count (longest time, rounds down)
`define SCA_CLK_NS          100
`define SCA_T_EEC_US        10000
`define SCA_EEC_CYCLES      ((`SCA_T_EEC_US * 1000) / `SCA_CLK_NS)

// Hash initial values and round constants
`define SCA_H0              32'h6745_2301
`define SCA_H1              32'hefcd_ab89
`define SCA_H2              32'h98ba_dcfe
`define SCA_H3              32'h1032_5476
`define SCA_H4              32'hc3d2_e1f0
`define SCA_K0              32'h5a82_7999
`define SCA_K1              32'h6ed9_eba1
`define SCA_K2              32'h8f1b_bcdc
`define SCA_K3              32'hca62_c1d6

`endif

// file: sca_pkg.sv
package sca_pkg;

	typedef enum logic [1:0] {
		SCA_IDLE = 2'b00,
		SCA_HASH = 2'b01,
		SCA_PROG = 2'b11
	} sca_state_t;

	typedef enum logic {
		SCA_JOB_MAC  = 1'b0,
		SCA_JOB_NEXT = 1'b1
	} sca_job_t;

endpackage

// file: sca_crc8.sv
`include "sca_defs.svh"

module sca_crc8 (
	// Family code and serial number, family in the low byte
	input  wire logic [55:0] data,
	// Resulting check byte
	output logic      [7:0]  crc
);

	always_comb begin
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 56; i++) begin
			if (r[0] ^ data[i]) begin
				r = (r >> 1) ^ 8'h8c;
			end else begin
				r = r >> 1;
			end
		end
		crc = r;
	end

endmodule

// file: sca_sha1_core.sv
`include "sca_defs.svh"

module sca_sha1_core (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Start pulse and message block, first word in the top bits
	input  wire logic         start,
	input  wire logic [511:0] block,
	// Result
	output logic              done,
	output logic      [159:0] digest
);

	logic [31:0]  a_q, b_q, c_q, d_q, e_q;
	logic [31:0]  a_d, b_d, c_d, d_d, e_d;
	logic [31:0]  w_q [16];
	logic [31:0]  w_d [16];
	logic [6:0]   t_q, t_d;
	logic         run_q, run_d;
	logic         done_q, done_d;
	logic [159:0] dig_q, dig_d;

	always_comb begin
		logic [31:0] f;
		logic [31:0] k;
		logic [31:0] tmp;
		logic [31:0] nw;
		f = 32'h0;
		k = 32'h0;
		tmp = 32'h0;
		nw = 32'h0;
		a_d = a_q;
		b_d = b_q;
		c_d = c_q;
		d_d = d_q;
		e_d = e_q;
		w_d = w_q;
		t_d = t_q;
		run_d = run_q;
		done_d = 1'b0;
		dig_d = dig_q;
		if (start) begin
			for (int i = 0; i < 16; i++) begin
				w_d[i] = block[511 - 32 * i -: 32];
			end
			a_d = `SCA_H0;
			b_d = `SCA_H1;
			c_d = `SCA_H2;
			d_d = `SCA_H3;
			e_d = `SCA_H4;
			t_d = 7'h00;
			run_d = 1'b1;
		end else if (run_q) begin
			if (t_q < 7'h14) begin
				f = (b_q & c_q) | (~b_q & d_q);
				k = `SCA_K0;
			end else if (t_q < 7'h28) begin
				f = b_q ^ c_q ^ d_q;
				k = `SCA_K1;
			end else if (t_q < 7'h3c) begin
				f = (b_q & c_q) | (b_q & d_q) | (c_q & d_q);
				k = `SCA_K2;
			end else begin
				f = b_q ^ c_q ^ d_q;
				k = `SCA_K3;
			end
			tmp = {a_q[26:0], a_q[31:27]} + f + e_q + k + w_q[0];
			nw = w_q[13] ^ w_q[8] ^ w_q[2] ^ w_q[0];
			for (int i = 0; i < 15; i++) begin
				w_d[i] = w_q[i + 1];
			end
			w_d[15] = {nw[30:0], nw[31]};
			e_d = d_q;
			d_d = c_q;
			c_d = {b_q[1:0], b_q[31:2]};
			b_d = a_q;
			a_d = tmp;
			t_d = t_q + 7'h01;
			if (t_q == `SCA_SHA_LAST_ROUND) begin
				run_d = 1'b0;
				done_d = 1'b1;
				dig_d = {`SCA_H0 + tmp, `SCA_H1 + a_q,
					`SCA_H2 + {b_q[1:0], b_q[31:2]},
					`SCA_H3 + c_q, `SCA_H4 + d_q};
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			a_q <= 32'h0;
			b_q <= 32'h0;
			c_q <= 32'h0;
			d_q <= 32'h0;
			e_q <= 32'h0;
			for (int i = 0; i < 16; i++) begin
				w_q[i] <= 32'h0;
			end
			t_q <= 7'h00;
			run_q <= 1'b0;
			done_q <= 1'b0;
			dig_q <= 160'h0;
		end else begin
			a_q <= a_d;
			b_q <= b_d;
			c_q <= c_d;
			d_q <= d_d;
			e_q <= e_d;
			w_q <= w_d;
			t_q <= t_d;
			run_q <= run_d;
			done_q <= done_d;
			dig_q <= dig_d;
		end
	end

	assign done = done_q;
	assign digest = dig_q;

endmodule

// file: sca_auth.sv
// Contract
// [R1] Hold 64-bit identifier: family, serial, check byte
// [R2] Hash 512-bit block: secret, challenge, constants
// [R3] Identifier variants replace 64 constant bits
// [R4] Secret itself never leaves the device
// [R5] Digest streams out 160 bits, LSB first
// [R6] Command 0Ch loads 64-bit challenge, bytes follow
// [R7] Over eight challenge bytes: value undefined
// [R8] Host reloads challenge before each computation
// [R9] Command 36h hashes with all-ones identifier
// [R10] Command 35h hashes with own identifier
// [R11] Digest finishes within hash time after command
// [R12] Single-wire host clocks digest out after hash
// [R13] Two-wire command 39h returns identifier
// [R14] Two-wire 3Ah returns last digest
// [R15] Command 5Ah clears secret, writes EEPROM
// [R16] Command 30h makes new secret, ones identifier
// [R17] Command 33h makes new secret with identifier
// [R18] Host waits hash then write time after
// [R19] Command 60h sets lock; lock freezes secret
// [R20] Host waits write time after lock
// [R21] Check byte: zeroed register, LSB first feed
// [R22] New secret is low digest bits; busy ignores
// [R23] Constant block data is a design parameter
`include "sca_defs.svh"

module sca_auth
	import sca_pkg::*;
#(
	parameter logic [7:0]   FAMILY_CODE = 8'h5e,
	parameter logic [47:0]  SERIAL_NUM  = 48'h0000_0000_0001,
	parameter logic [319:0] CONST_DATA  = {10{32'h5a5a_a5a5}},
	parameter bit           TWO_WIRE    = 1'b0,
	parameter int           EEC_CYCLES  = `SCA_EEC_CYCLES
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Command byte from the link
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_code,
	// Argument bytes from the link
	input  wire logic       wr_valid,
	input  wire logic [7:0] wr_byte,
	// Serial answer to the link
	input  wire logic       rd_take,
	output logic            rd_valid,
	output logic            rd_bit,
	// Status
	output logic            busy,
	output logic            locked
);

	localparam int EW = $clog2(EEC_CYCLES + 1);
	localparam logic [EW-1:0] EEC_LAST = EW'(EEC_CYCLES - 1);

	// Identifier: family low, serial, check byte high
	logic [7:0]   id_crc;
	logic [63:0]  dev_id;

	sca_crc8 u_crc (
		.data ({SERIAL_NUM, FAMILY_CODE}),
		.crc  (id_crc)
	); // R21

	assign dev_id = {id_crc, SERIAL_NUM, FAMILY_CODE}; // R1

	sca_state_t   state_q, state_d;
	sca_job_t     job_q, job_d;
	logic         with_id_q, with_id_d;
	logic         start_q, start_d;
	logic [63:0]  chal_q, chal_d;
	logic [3:0]   chal_cnt_q, chal_cnt_d;
	logic         chal_on_q, chal_on_d;
	logic [63:0]  secret_q, secret_d;
	logic         lock_q, lock_d;
	logic [63:0]  pend_secret_q, pend_secret_d;
	logic         pend_lock_q, pend_lock_d;
	logic [EW-1:0] eec_cnt_q, eec_cnt_d;
	logic [159:0] digest_q, digest_d;
	logic [159:0] sh_q, sh_d;
	logic [7:0]   left_q, left_d;
	logic         rd_valid_q, rd_valid_d;
	logic         busy_q, busy_d;

	logic         sha_done;
	logic [159:0] sha_digest;
	logic [511:0] block;

	// Secret, challenge, identifier slot, remaining constants
	assign block = {secret_q, chal_q,
		with_id_q ? dev_id : {64{1'b1}}, // R3 R9 R10
		CONST_DATA}; // R2 R23

	sca_sha1_core u_sha (
		.clock  (clock),
		.rst    (rst),
		.start  (start_q),
		.block  (block),
		.done   (sha_done),
		.digest (sha_digest)
	);

	function automatic logic is_hash_cmd(input logic [7:0] c);
		return c == `SCA_CMD_MAC_ANON || c == `SCA_CMD_MAC_ID ||
			c == `SCA_CMD_NEXT_ANON || c == `SCA_CMD_NEXT_ID;
	endfunction

	always_comb begin
		state_d = state_q;
		job_d = job_q;
		with_id_d = with_id_q;
		start_d = 1'b0;
		chal_d = chal_q;
		chal_cnt_d = chal_cnt_q;
		chal_on_d = chal_on_q;
		secret_d = secret_q;
		lock_d = lock_q;
		pend_secret_d = pend_secret_q;
		pend_lock_d = pend_lock_q;
		eec_cnt_d = eec_cnt_q;
		digest_d = digest_q;
		sh_d = sh_q;
		left_d = left_q;

		// Shift the answer out one bit per take
		if (rd_take && rd_valid_q) begin
			sh_d = {1'b0, sh_q[159:1]}; // R5
			left_d = left_q - 8'h01;
		end

		// Challenge bytes, low byte first; extras dropped
		if (wr_valid && chal_on_q && state_q == SCA_IDLE) begin
			if (chal_cnt_q < `SCA_CHAL_BYTES) begin
				chal_d[chal_cnt_q[2:0] * 8 +: 8] = wr_byte; // R6
				chal_cnt_d = chal_cnt_q + 4'h1;
			end // R7
		end

		unique case (state_q)
			SCA_IDLE: begin
				if (cmd_valid) begin // R22
					chal_on_d = 1'b0;
					left_d = 8'h00;
					if (cmd_code == `SCA_CMD_WR_CHAL) begin
						chal_on_d = 1'b1; // R6
						chal_cnt_d = 4'h0;
					end else if (is_hash_cmd(cmd_code)) begin
						with_id_d = cmd_code == `SCA_CMD_MAC_ID ||
							cmd_code == `SCA_CMD_NEXT_ID; // R10 R17
						if (cmd_code == `SCA_CMD_MAC_ANON ||
							cmd_code == `SCA_CMD_MAC_ID) begin
							job_d = SCA_JOB_MAC;
							start_d = 1'b1; // R11
							state_d = SCA_HASH;
						end else if (!lock_q) begin
							job_d = SCA_JOB_NEXT; // R16 R17
							start_d = 1'b1;
							state_d = SCA_HASH;
						end // R19
					end else if (cmd_code == `SCA_CMD_CLR_SECRET) begin
						if (!lock_q) begin // R19
							pend_secret_d = 64'h0; // R15
							pend_lock_d = lock_q;
							eec_cnt_d = '0;
							state_d = SCA_PROG;
						end
					end else if (cmd_code == `SCA_CMD_LOCK) begin
						pend_secret_d = secret_q;
						pend_lock_d = 1'b1; // R19
						eec_cnt_d = '0;
						state_d = SCA_PROG;
					end else if (TWO_WIRE &&
						cmd_code == `SCA_CMD_FETCH_ID) begin
						sh_d = {96'h0, dev_id}; // R13
						left_d = `SCA_ID_LEN;
					end else if (TWO_WIRE &&
						cmd_code == `SCA_CMD_FETCH_MAC) begin
						sh_d = digest_q; // R14
						left_d = `SCA_DIGEST_LEN;
					end
				end
			end
			SCA_HASH: begin
				if (sha_done) begin
					if (job_q == SCA_JOB_MAC) begin
						digest_d = sha_digest;
						state_d = SCA_IDLE;
						if (!TWO_WIRE) begin
							// Only the digest is ever loaded here
							sh_d = sha_digest; // R4 R5
							left_d = `SCA_DIGEST_LEN;
						end
					end else begin
						pend_secret_d = sha_digest[63:0]; // R22
						pend_lock_d = lock_q;
						eec_cnt_d = '0;
						state_d = SCA_PROG;
					end
				end
			end
			SCA_PROG: begin
				if (eec_cnt_q == EEC_LAST) begin
					secret_d = pend_secret_q; // R15 R16 R17
					lock_d = pend_lock_q; // R19
					state_d = SCA_IDLE;
				end else begin
					eec_cnt_d = eec_cnt_q + EW'(1);
				end
			end
			default: begin
				state_d = SCA_IDLE;
			end
		endcase

		rd_valid_d = left_d != 8'h00;
		busy_d = state_d != SCA_IDLE; // R22
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= SCA_IDLE;
			job_q <= SCA_JOB_MAC;
			with_id_q <= 1'b0;
			start_q <= 1'b0;
			chal_q <= 64'h0;
			chal_cnt_q <= 4'h0;
			chal_on_q <= 1'b0;
			secret_q <= `SCA_SECRET_RST;
			lock_q <= `SCA_LOCK_RST;
			pend_secret_q <= 64'h0;
			pend_lock_q <= 1'b0;
			eec_cnt_q <= '0;
			digest_q <= 160'h0;
			sh_q <= 160'h0;
			left_q <= 8'h00;
			rd_valid_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			job_q <= job_d;
			with_id_q <= with_id_d;
			start_q <= start_d;
			chal_q <= chal_d;
			chal_cnt_q <= chal_cnt_d;
			chal_on_q <= chal_on_d;
			secret_q <= secret_d;
			lock_q <= lock_d;
			pend_secret_q <= pend_secret_d;
			pend_lock_q <= pend_lock_d;
			eec_cnt_q <= eec_cnt_d;
			digest_q <= digest_d;
			sh_q <= sh_d;
			left_q <= left_d;
			rd_valid_q <= rd_valid_d;
			busy_q <= busy_d;
		end
	end

	assign rd_valid = rd_valid_q;
	assign rd_bit = sh_q[0];
	assign busy = busy_q;
	assign locked = lock_q;

endmodule

// file: sca_auth_checker.sv
module sca_auth_checker #(
	parameter int EEC_CYCLES = 8
) (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Link side
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic       wr_valid,
	input wire logic [7:0] wr_byte,
	input wire logic       rd_take,
	// Answer and status
	input wire logic       rd_valid,
	input wire logic       rd_bit,
	input wire logic       busy,
	input wire logic       locked
);
	localparam int EEC_HI   = EEC_CYCLES + 1;
	localparam int LOCK_DLY = EEC_CYCLES + 2;
	logic acc;
	logic mac;
	logic guarded;
	assign acc     = cmd_valid && !busy;
	assign mac     = cmd_code == 8'h36 || cmd_code == 8'h35;
	assign guarded = cmd_code == 8'h5a || cmd_code == 8'h30
		|| cmd_code == 8'h33;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	property p_mac_busy;
		acc && mac |=> busy [*8];
	endproperty
	a_mac_busy: assert property (p_mac_busy)
		else $error("hash job not busy");
	property p_mac_done;
		acc && mac |-> ##83 (!busy && rd_valid);
	endproperty
	a_mac_done: assert property (p_mac_done)
		else $error("digest not ready in time");
	property p_clear_time;
		acc && !locked && cmd_code == 8'h5a |=> busy ##EEC_HI !busy;
	endproperty
	a_clear_time: assert property (p_clear_time)
		else $error("clear write time wrong");
	property p_lock_time;
		acc && cmd_code == 8'h60 |-> ##LOCK_DLY (locked && !busy);
	endproperty
	a_lock_time: assert property (p_lock_time)
		else $error("lock bit not set in time");
	property p_lock_sticky;
		locked |=> locked;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky)
		else $error("lock bit dropped");
	property p_lock_refuse;
		acc && locked && guarded |=> !busy;
	endproperty
	a_lock_refuse: assert property (p_lock_refuse)
		else $error("secret change started while locked");
	property p_rd_rise;
		$rose(rd_valid) |-> $fell(busy);
	endproperty
	a_rd_rise: assert property (p_rd_rise)
		else $error("answer without finished hash");
	property p_rd_hold;
		rd_valid && !rd_take && !cmd_valid |=> rd_valid && $stable(rd_bit);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("answer bit moved without take");
	property p_busy_quiet;
		busy |-> !rd_valid;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("answer while busy");
endmodule

bind sca_auth sca_auth_checker #(.EEC_CYCLES(EEC_CYCLES)) sca_auth_checker_inst (
	.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.wr_valid(wr_valid), .wr_byte(wr_byte), .rd_take(rd_take),
	.rd_valid(rd_valid), .rd_bit(rd_bit), .busy(busy), .locked(locked)
);

// file: sca_host.sv
module sca_host (
	// Clock
	input wire logic       clock,
	// Answer bit
	input wire logic       rd_bit,
	// Requests
	output logic           cmd_valid,
	output logic [7:0]     cmd_code,
	output logic           wr_valid,
	output logic [7:0]     wr_byte,
	output logic           rd_take
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid = 1'h0;
		cmd_code = 8'h00;
		wr_valid = 1'h0;
		wr_byte = 8'h00;
		rd_take = 1'h0;
	end

	// Command pulse, then argument bytes low first; idle lines toggle
	task automatic op(input logic [7:0] code, input logic [63:0] ch,
		input int nb);
		@(posedge clock);
		cmd_valid <= 1'h1;
		cmd_code <= code;
		@(posedge clock);
		cmd_valid <= 1'h0;
		cmd_code <= ~code;
		for (int i = 0; i < nb; i++) begin
			wr_valid <= 1'h1;
			wr_byte <= ch[8 * i +: 8];
			@(posedge clock);
		end
		wr_valid <= 1'h0;
		wr_byte <= ~wr_byte;
	endtask

	task automatic get(input int n, output logic [159:0] v);
		v = 160'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			v[i] = rd_bit;
			rd_take <= 1'h1;
			@(posedge clock);
			rd_take <= 1'h0;
		end
	endtask
endmodule

// file: tb_top.sv
`include "sca_defs.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [7:0]  cmd;
		logic [63:0] ch;
	} sca_row_t;
	// Arbitrary family value
	localparam logic [7:0]   FAM   = 8'h5e;
	localparam logic [47:0]  SER   = 48'h0123_4567_89ab;
	localparam logic [319:0] CDATA = {10{32'h1357_9bdf}};
	localparam logic [63:0]  C1    = 64'h0123_4567_89ab_cdef;
	localparam logic [63:0]  C2    = 64'hfedc_ba98_7654_3210;
	localparam logic [63:0]  C3    = 64'hffff_0000_a5a5_5a5a;
	logic         clock, rst, cmd_valid, wr_valid, rd_take;
	logic         rd_valid, rd_bit, busy, locked;
	logic [7:0]   cmd_code, wr_byte;
	logic [159:0] got, exp_d;
	logic [63:0]  sec, uid;
	int           failures, n_compared;
	sca_row_t     rows[8];

	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end

	sca_auth #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .CONST_DATA(CDATA),
		.TWO_WIRE(1'h0), .EEC_CYCLES(8)) sca_auth_inst (
		.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .wr_valid(wr_valid), .wr_byte(wr_byte),
		.rd_take(rd_take), .rd_valid(rd_valid), .rd_bit(rd_bit),
		.busy(busy), .locked(locked));
	sca_host sca_host_inst (.clock(clock), .rd_bit(rd_bit),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_valid(wr_valid),
		.wr_byte(wr_byte), .rd_take(rd_take));

	function automatic logic [7:0] crc8(logic [55:0] x);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++)
			c = (c >> 1) ^ ((c[0] ^ x[i]) ? 8'h8c : 8'h00);
		return c;
	endfunction

	function automatic logic [159:0] sha1(logic [511:0] m);
		logic [31:0] w[80];
		logic [31:0] a, b, c, d, e, f, k, t;
		a = `SCA_H0;
		b = `SCA_H1;
		c = `SCA_H2;
		d = `SCA_H3;
		e = `SCA_H4;
		for (int i = 0; i < 80; i++) begin
			if (i < 16) begin
				w[i] = m[511 - 32 * i -: 32];
			end else begin
				t = w[i - 3] ^ w[i - 8] ^ w[i - 14] ^ w[i - 16];
				w[i] = {t[30:0], t[31]};
			end
			f = i < 20 ? (b & c) | (~b & d) : (i < 40 || i >= 60) ? b ^ c ^ d
				: (b & c) | (b & d) | (c & d);
			k = i < 20 ? `SCA_K0 : i < 40 ? `SCA_K1 : i < 60 ? `SCA_K2 : `SCA_K3;
			t = {a[26:0], a[31:27]} + f + e + k + w[i];
			e = d;
			d = c;
			c = {b[1:0], b[31:2]};
			b = a;
			a = t;
		end
		return {a + `SCA_H0, b + `SCA_H1, c + `SCA_H2, d + `SCA_H3, e + `SCA_H4};
	endfunction

	function automatic logic [159:0] mac_of(logic [7:0] c, logic [63:0] ch);
		logic [63:0] idf;
		idf = (c == 8'h35 || c == 8'h33) ? uid : 64'hffff_ffff_ffff_ffff;
		return sha1({sec, ch, idf, CDATA});
	endfunction

	task automatic chk(string nm, logic [159:0] e, logic [159:0] g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask

	task automatic give_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic settle;
		repeat (2) @(posedge clock);
		for (int i = 0; i < 300 && busy !== 1'h0; i++)
			@(posedge clock);
		if (busy !== 1'h0) begin
			failures++;
			give_verdict();
		end
	endtask

	task automatic mac_run(logic [7:0] c, logic [63:0] ch);
		sca_host_inst.op(8'h0c, ch, 8);
		sca_host_inst.op(c, 64'h0, 0);
		settle();
		sca_host_inst.get(160, got);
		@(posedge clock);
		chk("digest", mac_of(c, ch), got);
		chk("valid after stream", 160'h0, 160'(rd_valid));
	endtask

	initial begin
		rst = 1'h1;
		failures = 0;
		n_compared = 0;
		sec = 64'h0;
		uid = {crc8({SER, FAM}), SER, FAM};
		rows = '{'{8'h36, C1}, '{8'h35, C1}, '{8'h30, C2}, '{8'h36, C1},
			'{8'h33, C3}, '{8'h35, C2}, '{8'h5a, C1}, '{8'h36, C2}};
		repeat (6) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		chk("reset status", 160'h0, 160'({busy, locked, rd_valid, rd_bit}));
		foreach (rows[i]) begin
			if (rows[i].cmd == 8'h36 || rows[i].cmd == 8'h35) begin
				mac_run(rows[i].cmd, rows[i].ch);
			end else begin
				sca_host_inst.op(8'h0c, rows[i].ch, 8);
				sca_host_inst.op(rows[i].cmd, 64'h0, 0);
				settle();
				exp_d = mac_of(rows[i].cmd, rows[i].ch);
				sec = rows[i].cmd == 8'h5a ? 64'h0 : exp_d[63:0];
			end
		end
		// Clear issued during a running job is dropped
		sca_host_inst.op(8'h0c, C2, 8);
		sca_host_inst.op(8'h30, 64'h0, 0);
		sca_host_inst.op(8'h5a, 64'h0, 0);
		settle();
		exp_d = mac_of(8'h30, C2);
		sec = exp_d[63:0];
		mac_run(8'h36, C3);
		// Stream cut short by the next command
		sca_host_inst.op(8'h0c, C2, 8);
		sca_host_inst.op(8'h35, 64'h0, 0);
		settle();
		sca_host_inst.get(10, got);
		chk("first bits", mac_of(8'h35, C2) & 160'h3ff, got);
		mac_run(8'h35, C1);
		// Lock, then secret changes by 33h here and 5Ah below are refused
		sca_host_inst.op(8'h60, 64'h0, 0);
		settle();
		chk("lock bit", 160'h1, 160'(locked));
		sca_host_inst.op(8'h0c, C3, 8);
		sca_host_inst.op(8'h33, 64'h0, 0);
		repeat (2) @(posedge clock);
		chk("busy while locked", 160'h0, 160'(busy));
		// Identifier fetch is a two-wire command only
		sca_host_inst.op(8'h39, 64'h0, 0);
		repeat (2) @(posedge clock);
		chk("no id answer", 160'h0, 160'({rd_valid, busy}));
		sca_host_inst.op(8'h5a, 64'h0, 0);
		settle();
		mac_run(8'h36, C1);
		// Second reset while idle, after the last stream
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		sec = 64'h0;
		@(posedge clock);
		chk("lock after reset", 160'h0, 160'(locked));
		mac_run(8'h35, C3);
		give_verdict();
	end
endmodule
